// File: rlo_meas_model.sv
// rlo_meas_model: stand-in for the power stage measurement path.
// assumes the bench sets the link voltage and motor current that it wants reported.
`timescale 1ns/1ps
module rlo_meas_model
   import rlo_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic rst, // async reset, high
   input wire logic [VOLT_W-1:0] volt_lvl, // voltage to report, V
   input wire logic [CUR_W-1:0] cur_lvl, // current to report, 0.1 A
   output rlo_meas_t meas // sampled measurements
);
   // one-clock sample like a converter, so a new level lands a cycle late
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         meas <= '0; // nothing measured yet
      end
      else
      begin
         meas.measured_link_voltage <= volt_lvl; // link voltage sample
         meas.motor_current <= cur_lvl; // output current sample
      end
   end
endmodule : rlo_meas_model

// File: rlo_pkg.sv
// rlo_pkg: constants, mode and state types, and carriers for the ramp limit override.
// assumes settings arrive in the units below: time 0.1 s, voltage 1 V, current 0.1 A, gain 0.01.
package rlo_pkg;
   // data widths
   localparam int SPD_W = 16; // integer rpm
   localparam int FRAC_W = 8; // fraction bits of the ramp accumulator
   localparam int ACC_W = SPD_W + FRAC_W; // fixed-point ramp width
   localparam int VOLT_W = 11; // link voltage, volts
   localparam int CUR_W = 11; // current, 0.1 A
   localparam int GAIN_W = 10; // gain, 0.01 units
   localparam int TIME_W = 14; // ramp time, 0.1 s
   localparam int CLASS_W = 2; // supply class
   // third ramp time, 0.1 s units
   localparam logic [TIME_W-1:0] RAMP3_MIN = 14'h0001; // 0.1 s
   localparam logic [TIME_W-1:0] RAMP3_MAX = 14'h2706; // 999.0 s
   localparam logic [TIME_W-1:0] RAMP3_DFLT = 14'h0032; // 5.0 s
   // link voltage actuation level, volts
   localparam logic [VOLT_W-1:0] VLEVEL_MIN = 11'h153; // 339 V
   localparam logic [VOLT_W-1:0] VLEVEL_MAX = 11'h4B0; // 1200 V
   localparam logic [VOLT_W-1:0] VLEVEL_DFLT0 = 11'h190; // 400 V, class 0
   localparam logic [VOLT_W-1:0] VLEVEL_DFLT1 = 11'h320; // 800 V, class 1
   localparam logic [VOLT_W-1:0] VLEVEL_DFLT2 = 11'h3E8; // 1000 V, class 2
   localparam logic [CLASS_W-1:0] CLASS_1 = 2'h1;
   localparam logic [CLASS_W-1:0] CLASS_2 = 2'h2;
   // proportional gain, 0.01 units
   localparam logic [GAIN_W-1:0] GAIN_MAX = 10'h3E7; // 9.99
   localparam logic [GAIN_W-1:0] GAIN_DFLT = 10'h096; // 1.50
   // gain/100 done as multiply by 655 then shift 16: 0.05 % low, avoids a divider
   localparam logic [15:0] GAIN_RECIP = 16'h028F;
   localparam int GAIN_SHIFT = 16;
   // output current threshold, 0.1 A
   localparam logic [CUR_W-1:0] CUR_MAX = 11'h7D0; // 200.0 A
   localparam int CUR_DFLT_NUM = 3; // default is 3/2 of rated current
   localparam int CUR_DFLT_SH = 1;

   // limitation mode, in setting order 0..3
   typedef enum logic [1:0]
   {
      MODE_VHOLD_CDEC,
      MODE_VACC_CDEC,
      MODE_VHOLD_CHOLD,
      MODE_VACC_CHOLD
   } rlo_mode_t;
   localparam rlo_mode_t LIMIT_MODE_DFLT = MODE_VHOLD_CDEC;

   // ramp control states
   typedef enum logic [2:0]
   {
      RS_TRACK,
      RS_VHOLD,
      RS_VACCEL,
      RS_CHOLD,
      RS_CDEC
   } rlo_state_t;

   // settings carrier
   typedef struct packed
   {
      rlo_mode_t limit_mode_select;
      logic [TIME_W-1:0] third_ramp_time; // 0 selects default
      logic [VOLT_W-1:0] link_voltage_limit_level; // 0 selects class default
      logic [GAIN_W-1:0] link_voltage_gain; // above max selects default
      logic [CUR_W-1:0] max_output_current; // 0 selects 1.5 x rated
      logic [CUR_W-1:0] rated_current;
      logic [SPD_W-1:0] maximum_speed;
      logic [SPD_W-1:0] minimum_speed;
      logic [CLASS_W-1:0] supply_class_select;
   } rlo_cfg_t;

   // measurement carrier
   typedef struct packed
   {
      logic [VOLT_W-1:0] measured_link_voltage;
      logic [CUR_W-1:0] motor_current;
   } rlo_meas_t;
endpackage : rlo_pkg

// File: rlo_ramp_limit_override.sv
// rlo_ramp_limit_override: speed ramp with link voltage and output current override.
// assumes synchronous inputs, a one-cycle tick pulse per control period, steady settings.
//
// Function
// - third ramp time 0.1..999.0 s, default 5.0
// - limitation stops tracking, holds the ramp or moves at third rate
// - voltage limitation wins over current limitation
// - mode 0..3 decodes hold/accel and decel/hold
// - voltage hold freezes ramp while decelerating only
// - voltage accel adds gain times error always
// - level 339..1200 V, class default 400/800/1000
// - gain 0.00..9.99, default 1.50
// - current hold freezes ramp while moving
// - current decel ramps toward minimum speed at third rate, then recovers
// - current threshold 0..200.0 A, default 1.5x rated
// - third ramp overrides first and second ramps
`timescale 1ns/1ps
module rlo_ramp_limit_override
   import rlo_pkg::*;
#(
   parameter int TICKS_PER_DS = 100 // control ticks per 0.1 s
)
(
   input wire logic clk_sys, // system clock, 200 MHz
   input wire logic rst, // async reset, high
   input wire logic ce, // clock enable, low freezes all state
   input wire logic tick, // control tick pulse
   input wire rlo_cfg_t cfg, // settings
   input wire rlo_meas_t meas, // measured voltage and current
   input wire logic [SPD_W-1:0] speed_ref, // speed reference, rpm
   input wire logic [ACC_W-1:0] normal_step, // first/second ramp step per tick
   output logic [SPD_W-1:0] speed_cmd, // commanded speed, rpm
   output logic volt_limit_active, // voltage limitation overriding
   output logic cur_limit_active, // current limitation overriding
   output rlo_state_t ramp_state // present override state
);
   // ramp ticks must fit the divider width
   if (TICKS_PER_DS < 1 || TICKS_PER_DS > 1679)
   begin : g_chk
      $error("rlo_ramp_limit_override: TICKS_PER_DS out of range");
   end

   localparam int PROD_W = GAIN_W + VOLT_W + 16; // correction product width

   // registers and their next values
   logic [ACC_W-1:0] ramp_ff; // ramp accumulator, fixed point
   logic [SPD_W-1:0] speed_cmd_ff; // output speed
   logic volt_lim_ff; // voltage status
   logic cur_lim_ff; // current status
   rlo_state_t state_ff; // override state
   logic [ACC_W-1:0] nxt_ramp; // next ramp value
   logic [SPD_W-1:0] nxt_speed_cmd; // next output speed
   rlo_state_t nxt_state; // next state

   // settings with defaults and range limits
   wire logic [TIME_W-1:0] time_eff = (cfg.third_ramp_time == '0) ? RAMP3_DFLT :
      (cfg.third_ramp_time > RAMP3_MAX) ? RAMP3_MAX : cfg.third_ramp_time;
   wire logic [VOLT_W-1:0] class_level = (cfg.supply_class_select == CLASS_1) ? VLEVEL_DFLT1 :
      (cfg.supply_class_select == CLASS_2) ? VLEVEL_DFLT2 : VLEVEL_DFLT0;
   wire logic [VOLT_W-1:0] level_eff = (cfg.link_voltage_limit_level == '0) ? class_level :
      (cfg.link_voltage_limit_level < VLEVEL_MIN) ? VLEVEL_MIN :
      (cfg.link_voltage_limit_level > VLEVEL_MAX) ? VLEVEL_MAX : cfg.link_voltage_limit_level;
   wire logic [GAIN_W-1:0] gain_eff = (cfg.link_voltage_gain > GAIN_MAX) ? GAIN_DFLT :
      cfg.link_voltage_gain;
   wire logic [CUR_W+1:0] cur_dflt = (CUR_W+2)'((cfg.rated_current * CUR_DFLT_NUM) >> CUR_DFLT_SH);
   wire logic [CUR_W+1:0] cur_pick = (cfg.max_output_current == '0) ? cur_dflt :
      {2'h0, cfg.max_output_current};
   wire logic [CUR_W-1:0] cur_eff = (cur_pick > {2'h0, CUR_MAX}) ? CUR_MAX : cur_pick[CUR_W-1:0];

   // mode decode
   wire logic v_acc_mode = (cfg.limit_mode_select == MODE_VACC_CDEC) ||
      (cfg.limit_mode_select == MODE_VACC_CHOLD);
   wire logic c_hold_mode = (cfg.limit_mode_select == MODE_VHOLD_CHOLD) ||
      (cfg.limit_mode_select == MODE_VACC_CHOLD);

   // fixed-point speed bounds and reference
   wire logic [ACC_W-1:0] max_fx = {cfg.maximum_speed, {FRAC_W{1'b0}}};
   wire logic [ACC_W-1:0] min_fx = {cfg.minimum_speed, {FRAC_W{1'b0}}};
   wire logic [ACC_W-1:0] raw_fx = {speed_ref, {FRAC_W{1'b0}}};
   wire logic [ACC_W-1:0] ref_fx = (raw_fx > max_fx) ? max_fx : (raw_fx < min_fx) ? min_fx : raw_fx;
   wire logic decel = ref_fx < ramp_ff; // ramp heading down
   wire logic moving = ref_fx != ramp_ff; // ramp not settled

   // third ramp step from divider
   wire logic [ACC_W-1:0] ramp_ticks = ACC_W'(time_eff * TICKS_PER_DS);
   logic [ACC_W-1:0] step3; // third ramp step per tick
   rlo_step_div #(.W(ACC_W)) u_div
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .num(max_fx),
      .den(ramp_ticks),
      .quo(step3)
   );

   // limit detection and arbitration
   wire logic volt_hit = meas.measured_link_voltage >= level_eff; // level reached
   wire logic cur_hit = meas.motor_current > cur_eff; // above threshold
   wire logic volt_act = volt_hit & (v_acc_mode | decel);
   wire logic cur_act = cur_hit & (~c_hold_mode | moving) & ~volt_act;

   // proportional correction in rpm, only above the level
   wire logic [VOLT_W-1:0] v_err = volt_hit ? VOLT_W'(meas.measured_link_voltage - level_eff) : '0;
   wire logic [PROD_W-1:0] corr_full = PROD_W'(gain_eff) * PROD_W'(v_err) * PROD_W'(GAIN_RECIP);
   wire logic corr_sat = |corr_full[PROD_W-1:GAIN_SHIFT+SPD_W]; // overflows rpm range
   wire logic [SPD_W-1:0] corr = corr_sat ? '1 : corr_full[GAIN_SHIFT+SPD_W-1:GAIN_SHIFT];

   // next state: voltage first, then current, else track
   always_comb
   begin
      if (volt_act)
      begin
         nxt_state = v_acc_mode ? RS_VACCEL : RS_VHOLD;
      end
      else if (cur_act)
      begin
         nxt_state = c_hold_mode ? RS_CHOLD : RS_CDEC;
      end
      else
      begin
         nxt_state = RS_TRACK;
      end
   end

   // move the ramp toward its target without overshoot
   function automatic logic [ACC_W-1:0] step_to(input logic [ACC_W-1:0] cur, input logic [ACC_W-1:0] tgt,
      input logic [ACC_W-1:0] stp);
      logic [ACC_W-1:0] gap;
      gap = (tgt > cur) ? tgt - cur : cur - tgt;
      if (gap <= stp)
      begin
         step_to = tgt;
      end
      else
      begin
         step_to = (tgt > cur) ? cur + stp : cur - stp;
      end
   endfunction : step_to

   // ramp update per state
   always_comb
   begin
      case (nxt_state)
         RS_TRACK: nxt_ramp = step_to(ramp_ff, ref_fx, normal_step); // ordinary ramp
         RS_CDEC: nxt_ramp = step_to(ramp_ff, min_fx, step3);
         RS_VHOLD: nxt_ramp = ramp_ff;
         RS_CHOLD: nxt_ramp = ramp_ff;
         RS_VACCEL: nxt_ramp = ramp_ff; // correction does the pushing
         default: nxt_ramp = ramp_ff;
      endcase
   end

   // output = ramp plus correction, clamped to the maximum speed
   wire logic [SPD_W-1:0] corr_add = v_acc_mode ? corr : {SPD_W{1'b0}}; // correction in accelerate modes only
   wire logic [SPD_W:0] sum = {1'b0, nxt_ramp[ACC_W-1:FRAC_W]} + {1'b0, corr_add};
   assign nxt_speed_cmd = (sum > {1'b0, cfg.maximum_speed}) ? cfg.maximum_speed : sum[SPD_W-1:0];

   // state registers, advance on tick only
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ramp_ff <= '0;
         speed_cmd_ff <= '0;
         volt_lim_ff <= 1'b0;
         cur_lim_ff <= 1'b0;
         state_ff <= RS_TRACK;
      end
      else if (ce && tick)
      begin
         ramp_ff <= nxt_ramp;
         speed_cmd_ff <= nxt_speed_cmd;
         volt_lim_ff <= volt_act;
         cur_lim_ff <= cur_act;
         state_ff <= nxt_state;
      end
   end

   assign speed_cmd = speed_cmd_ff;
   assign volt_limit_active = volt_lim_ff;
   assign cur_limit_active = cur_lim_ff;
   assign ramp_state = state_ff;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   time_range_a: assert property (time_eff >= RAMP3_MIN && time_eff <= RAMP3_MAX)
      else $error("third ramp time outside range");
   cdec_rate_a: assert property (ce && tick && nxt_state == RS_CDEC |=>
      ramp_ff <= $past(ramp_ff) && ($past(ramp_ff) - ramp_ff) <= $past(step3))
      else $error("current decel step exceeds third ramp rate");
   volt_prec_a: assert property (ce && tick && volt_hit && (v_acc_mode || decel) |=>
      volt_lim_ff && !cur_lim_ff)
      else $error("current limit not yielding to voltage limit");
   mode_decode_a: assert property (ce && tick && volt_act |=>
      (state_ff == RS_VACCEL) == $past(cfg.limit_mode_select[0]))
      else $error("voltage mode decode wrong");
   vhold_freeze_a: assert property (ce && tick && nxt_state == RS_VHOLD |=>
      $stable(ramp_ff) && $past(decel))
      else $error("voltage hold did not freeze on decel");
   vacc_add_a: assert property (ce && tick && v_acc_mode && volt_hit |=>
      speed_cmd_ff >= $past(ramp_ff[ACC_W-1:FRAC_W]) || speed_cmd_ff == $past(cfg.maximum_speed))
      else $error("accel correction not added");
   level_range_a: assert property (level_eff >= VLEVEL_MIN && level_eff <= VLEVEL_MAX)
      else $error("voltage level outside range");
   gain_range_a: assert property (gain_eff <= GAIN_MAX)
      else $error("gain outside range");
   chold_freeze_a: assert property (ce && tick && nxt_state == RS_CHOLD |=>
      $stable(ramp_ff) && cur_lim_ff)
      else $error("current hold did not freeze");
   cur_range_a: assert property (cur_eff <= CUR_MAX)
      else $error("current threshold outside range");
   status_pair_a: assert property (ce && tick |=> !(volt_lim_ff && cur_lim_ff) &&
      (volt_lim_ff == (state_ff == RS_VHOLD || state_ff == RS_VACCEL)))
      else $error("status flags disagree with state");

   vhold_seen_c: cover property (ce && tick && nxt_state == RS_VHOLD);
   vaccel_seen_c: cover property (ce && tick && nxt_state == RS_VACCEL);
   cdec_seen_c: cover property (ce && tick && nxt_state == RS_CDEC ##[1:200] ce && tick && nxt_state == RS_TRACK);
   both_hit_c: cover property (ce && tick && volt_act && cur_hit);
endmodule : rlo_ramp_limit_override

// File: rlo_ramp_limit_override_test.sv
// rlo_ramp_limit_override_test: directed bench for the ramp limit override.
// assumes one tick per 0.1 s, max speed 3600 rpm, so the third ramp moves 72 rpm a tick.
`timescale 1ns/1ps
module rlo_ramp_limit_override_test;
   import rlo_pkg::*;
   logic clk_sys = 1'b0; // system clock
   logic rst = 1'b1; // reset, high
   logic tick = 1'b0; // control tick
   logic ce = 1'b1; // clock enable
   rlo_cfg_t cfg; // settings
   rlo_meas_t meas; // measured values
   logic [VOLT_W-1:0] volt_lvl = 11'h000; // reported voltage
   logic [CUR_W-1:0] cur_lvl = 11'h000; // reported current
   logic [SPD_W-1:0] speed_ref = 16'h0000; // speed reference
   logic [ACC_W-1:0] normal_step = 24'h000A00; // 10 rpm a tick
   logic [SPD_W-1:0] speed_cmd; // commanded speed
   logic volt_limit_active; // voltage flag
   logic cur_limit_active; // current flag
   rlo_state_t ramp_state; // override state
   int mismatches = 0; // failed compares
   int n_compared = 0; // all compares
   // gain 1.50 on a 100 V error, floored through the 655/65536 scaling
   localparam logic [SPD_W-1:0] CORR = 16'h0095;
   always #2.5 clk_sys = ~clk_sys; // 200 MHz
   rlo_ramp_limit_override #(.TICKS_PER_DS(1)) dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .tick(tick), .cfg(cfg),
      .meas(meas), .speed_ref(speed_ref), .normal_step(normal_step), .speed_cmd(speed_cmd),
      .volt_limit_active(volt_limit_active), .cur_limit_active(cur_limit_active), .ramp_state(ramp_state));
   rlo_meas_model model (.clk_sys(clk_sys), .rst(rst), .volt_lvl(volt_lvl), .cur_lvl(cur_lvl), .meas(meas));
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // all outputs at once
   task automatic expect_out(input logic [SPD_W-1:0] spd, input logic v, input logic c, input rlo_state_t st);
      check(speed_cmd, spd);
      check(volt_limit_active, v);
      check(cur_limit_active, c);
      check(ramp_state, st);
   endtask : expect_out
   // counts, verdict and end of run
   task automatic finish_test();
      $display("compares %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   // tick pulses launched just after an edge; outputs settled on return
   task automatic do_tick(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         #1 tick = 1'b1;
         @(posedge clk_sys);
         #1 tick = 1'b0;
      end
   endtask : do_tick
   // new levels, one clock to pass the model
   task automatic set_meas(input logic [VOLT_W-1:0] v, input logic [CUR_W-1:0] c);
      volt_lvl = v;
      cur_lvl = c;
      @(posedge clk_sys);
      #1;
   endtask : set_meas
   // ordinary ramp to r, no limitation, bounded
   task automatic settle(input logic [SPD_W-1:0] r);
      set_meas(11'h000, 11'h000);
      speed_ref = r;
      for (int i = 0; i < 400 && speed_cmd !== r; i++)
         do_tick(1);
      expect_out(r, 1'b0, 1'b0, RS_TRACK);
   endtask : settle
   // tracking from rest
   task automatic t_track();
      speed_ref = 16'h0064;
      do_tick(3);
      expect_out(16'h001E, 1'b0, 1'b0, RS_TRACK);
   endtask : t_track
   // hold modes freeze only while slowing, from the level upward, over current too
   task automatic t_vhold();
      for (int m = 0; m < 2; m++)
      begin
         cfg.limit_mode_select = m ? MODE_VHOLD_CHOLD : MODE_VHOLD_CDEC;
         settle(16'h0064);
         speed_ref = 16'h0000;
         set_meas(11'h190, 11'h0C9);
         do_tick(2);
         expect_out(16'h0064, 1'b1, 1'b0, RS_VHOLD);
         set_meas(11'h18F, 11'h000);
         do_tick(1);
         expect_out(16'h005A, 1'b0, 1'b0, RS_TRACK);
         speed_ref = 16'h00C8;
         set_meas(11'h190, 11'h000);
         do_tick(1);
         expect_out(16'h0064, 1'b0, 1'b0, RS_TRACK);
      end
   endtask : t_vhold
   // accelerate modes add gain times error at steady speed and while slowing
   task automatic t_vacc();
      for (int m = 0; m < 2; m++)
      begin
         cfg.limit_mode_select = m ? MODE_VACC_CHOLD : MODE_VACC_CDEC;
         settle(16'h0064);
         set_meas(11'h1F4, 11'h0C9);
         do_tick(2);
         expect_out(16'h0064 + CORR, 1'b1, 1'b0, RS_VACCEL);
         speed_ref = 16'h0000;
         do_tick(1);
         expect_out(16'h0064 + CORR, 1'b1, 1'b0, RS_VACCEL);
         speed_ref = 16'h0064;
         set_meas(11'h000, 11'h000);
         do_tick(1);
         expect_out(16'h0064, 1'b0, 1'b0, RS_TRACK);
      end
   endtask : t_vacc
   // current hold freezes both directions; equal current does not exceed
   task automatic t_chold();
      for (int m = 0; m < 2; m++)
      begin
         cfg.limit_mode_select = m ? MODE_VACC_CHOLD : MODE_VHOLD_CHOLD;
         settle(16'h0064);
         speed_ref = 16'h00C8;
         set_meas(11'h000, 11'h0C9);
         do_tick(2);
         expect_out(16'h0064, 1'b0, 1'b1, RS_CHOLD);
         speed_ref = 16'h0000;
         do_tick(1);
         expect_out(16'h0064, 1'b0, 1'b1, RS_CHOLD);
         set_meas(11'h000, 11'h0C8);
         do_tick(1);
         expect_out(16'h005A, 1'b0, 1'b0, RS_TRACK);
      end
   endtask : t_chold
   // current decel steps down on the third ramp, then recovers
   task automatic t_cdec();
      for (int m = 0; m < 2; m++)
      begin
         cfg.limit_mode_select = m ? MODE_VACC_CDEC : MODE_VHOLD_CDEC;
         settle(16'h012C);
         set_meas(11'h000, 11'h0C9);
         do_tick(1);
         expect_out(16'h00E4, 1'b0, 1'b1, RS_CDEC);
         do_tick(1);
         expect_out(16'h009C, 1'b0, 1'b1, RS_CDEC);
         set_meas(11'h000, 11'h000);
         do_tick(1);
         expect_out(16'h00A6, 1'b0, 1'b0, RS_TRACK);
      end
   endtask : t_cdec
   // zero or out-of-range settings fall back to their defaults
   task automatic t_dflt();
      cfg.limit_mode_select = LIMIT_MODE_DFLT;
      cfg.third_ramp_time = 14'h0000;
      cfg.link_voltage_limit_level = 11'h000;
      cfg.link_voltage_gain = 10'h3FF;
      cfg.max_output_current = 11'h000;
      cfg.supply_class_select = CLASS_1;
      repeat (60) @(posedge clk_sys); // divider refresh
      #1;
      settle(16'h012C);
      speed_ref = 16'h0000;
      set_meas(11'h31F, 11'h000);
      do_tick(1);
      expect_out(16'h0122, 1'b0, 1'b0, RS_TRACK);
      set_meas(11'h320, 11'h000);
      do_tick(1);
      expect_out(16'h0122, 1'b1, 1'b0, RS_VHOLD);
      cfg.supply_class_select = CLASS_2;
      set_meas(11'h3E7, 11'h000);
      do_tick(1);
      expect_out(16'h0118, 1'b0, 1'b0, RS_TRACK);
      set_meas(11'h3E8, 11'h000);
      do_tick(1);
      expect_out(16'h0118, 1'b1, 1'b0, RS_VHOLD);
      cfg.limit_mode_select = MODE_VACC_CDEC;
      speed_ref = 16'h0118;
      set_meas(11'h44C, 11'h000);
      do_tick(1);
      expect_out(16'h0118 + CORR, 1'b1, 1'b0, RS_VACCEL);
      set_meas(11'h000, 11'h096);
      do_tick(1);
      expect_out(16'h0118, 1'b0, 1'b0, RS_TRACK);
      set_meas(11'h000, 11'h097);
      do_tick(1);
      expect_out(16'h00D0, 1'b0, 1'b1, RS_CDEC);
   endtask : t_dflt
   // enable low ignores ticks; a reset in mid-run clears ramp and flags
   task automatic t_ce_rst();
      ce = 1'b0;
      do_tick(2);
      expect_out(16'h00D0, 1'b0, 1'b1, RS_CDEC);
      ce = 1'b1;
      set_meas(11'h000, 11'h000);
      do_tick(1);
      expect_out(16'h00DA, 1'b0, 1'b0, RS_TRACK);
      rst = 1'b1;
      @(posedge clk_sys);
      #1 rst = 1'b0;
      expect_out(16'h0000, 1'b0, 1'b0, RS_TRACK);
      @(posedge clk_sys);
      #1;
      expect_out(16'h0000, 1'b0, 1'b0, RS_TRACK);
      do_tick(1);
      expect_out(16'h000A, 1'b0, 1'b0, RS_TRACK);
   endtask : t_ce_rst
   // main sequence
   initial
   begin
      cfg.limit_mode_select = MODE_VHOLD_CDEC;
      cfg.third_ramp_time = RAMP3_DFLT;
      cfg.link_voltage_limit_level = VLEVEL_DFLT0;
      cfg.link_voltage_gain = GAIN_DFLT;
      cfg.max_output_current = 11'h0C8;
      cfg.rated_current = 11'h064;
      cfg.maximum_speed = 16'h0E10;
      cfg.minimum_speed = 16'h0000;
      cfg.supply_class_select = 2'h0;
      // the stand-in stage has no braking resistor, so voltage limitation stays enabled
      repeat (16) @(posedge clk_sys);
      #1 rst = 1'b0;
      @(posedge clk_sys);
      #1;
      expect_out(16'h0000, 1'b0, 1'b0, RS_TRACK);
      repeat (50) @(posedge clk_sys); // divider warm-up
      #1;
      t_track();
      t_vhold();
      t_vacc();
      t_chold();
      t_cdec();
      t_dflt();
      t_ce_rst();
      finish_test();
   end
   // watchdog, far beyond the few hundred cycles the run needs
   initial
   begin
      repeat (40000) @(posedge clk_sys);
      mismatches++;
      finish_test();
   end
endmodule : rlo_ramp_limit_override_test

// File: rlo_step_div.sv
// rlo_step_div: iterative unsigned divider giving the third-ramp step per tick.
// assumes slowly changing settings; result refreshes every W+1 enabled cycles.
`timescale 1ns/1ps
module rlo_step_div
   import rlo_pkg::*;
#(
   parameter int W = ACC_W
)
(
   input wire logic clk_sys, // system clock
   input wire logic rst, // async reset, high
   input wire logic ce, // clock enable
   input wire logic [W-1:0] num, // dividend
   input wire logic [W-1:0] den, // divisor, nonzero
   output logic [W-1:0] quo // last finished quotient
);
   logic [W:0] rem_ff; // partial remainder
   logic [W-1:0] dvd_ff; // dividend bits still to shift in
   logic [W-1:0] den_ff; // divisor snapshot
   logic [W-1:0] q_ff; // quotient under construction
   logic [W-1:0] quo_ff; // finished quotient
   logic [$clog2(W+1)-1:0] cnt_ff; // bits remaining, 0 = load
   wire logic [W:0] shifted = {rem_ff[W-1:0], dvd_ff[W-1]}; // next trial remainder
   wire logic fits = shifted >= {1'b0, den_ff}; // trial subtract succeeds
   wire logic loading = cnt_ff == '0; // start a new division

   if (W < 2)
   begin : g_chk
      $error("rlo_step_div: width too small");
   end

   // one quotient bit per enabled cycle after the load cycle
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rem_ff <= '0;
         dvd_ff <= '0;
         den_ff <= '0;
         q_ff <= '0;
         quo_ff <= '0;
         cnt_ff <= '0;
      end
      else if (ce)
      begin
         if (loading)
         begin
            rem_ff <= '0;
            dvd_ff <= num;
            den_ff <= den;
            q_ff <= '0;
            cnt_ff <= ($clog2(W+1))'(W);
         end
         else
         begin
            rem_ff <= fits ? shifted - {1'b0, den_ff} : shifted;
            dvd_ff <= {dvd_ff[W-2:0], 1'b0};
            q_ff <= {q_ff[W-2:0], fits};
            cnt_ff <= cnt_ff - 1'b1;
            // last bit: publish result
            if (cnt_ff == 1'b1)
            begin
               quo_ff <= {q_ff[W-2:0], fits};
            end
         end
      end
   end

   assign quo = quo_ff;
endmodule : rlo_step_div
